// >>> rtl/mmcf_unit.sv
// min/max/clip and float add/sub/abs-sum unit behind a classic wishbone slave
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module mmcf_unit
	import mmcf_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	// wishbone request
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [ADDR_W-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [DATA_W-1:0] WB_DAT_I,
	// wishbone answer
	output logic [DATA_W-1:0] WB_DAT_O,
	output logic WB_ACK_O
);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	if (ADDR_W < 8) begin : g_bad_addr
		$error("ADDR_W must be at least 8");
	end

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [1:0] mode;
		logic [OPND_W-1:0] src_a;
		logic [OPND_W-1:0] src_b;
		logic [OPND_W-1:0] res;
		mmcf_flags_t flags;
		logic [7:0] cmp_hist;
		logic [3:0] sticky;
		logic ack;
		logic [DATA_W-1:0] rdata;
	} mmcf_state_t;

	mmcf_state_t s;
	mmcf_state_t next_s;

	// ****************************************************************
	// functions
	// ****************************************************************

	// byte-lane merge of a write into a 32-bit word
	function automatic logic [31:0] merge_lanes(input logic [31:0] old,
			input logic [31:0] din, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = din[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// leading zero count of a nonzero word
	function automatic logic [5:0] lead_zeros(input logic [WORK_W-1:0] v);
		logic [5:0] n;
		logic found;
		n = '0;
		found = 1'b0;
		for (int i = WORK_W - 1; i >= 0; i--) begin
			if (!found) begin
				if (v[i]) begin
					found = 1'b1;
				end else begin
					n = n + 6'd1;
				end
			end
		end
		return n;
	endfunction

	// float add, subtract and abs-of-sum on the 40-bit format
	function automatic mmcf_fres_t fp_addsub(input logic [OPND_W-1:0] a,
			input logic [OPND_W-1:0] b, input logic sub, input logic absr,
			input logic trunc, input logic rnd32);
		mmcf_fres_t r;
		logic sa, sb, sl, ss, sr;
		logic nan_a, nan_b, inf_a, inf_b;
		logic [7:0] ea, eb, el, es;
		logic [WORK_W-1:0] ma, mb, ml, ms, sh, norm;
		logic [WORK_W:0] sum;
		logic [5:0] lz;
		logic signed [10:0] e;
		logic [32:0] kept;
		logic [32:0] unit;
		logic g, st, lsb;
		r = '0;
		sa = a[OPND_W-1];
		sb = b[OPND_W-1] ^ sub;
		ea = a[38:31];
		eb = b[38:31];
		nan_a = (ea == EXP_ALL1) && (a[FRAC_W-1:0] != '0);
		nan_b = (eb == EXP_ALL1) && (b[FRAC_W-1:0] != '0);
		inf_a = (ea == EXP_ALL1) && (a[FRAC_W-1:0] == '0);
		inf_b = (eb == EXP_ALL1) && (b[FRAC_W-1:0] == '0);
		ma = (ea == 8'h00) ? '0 : {1'b1, a[FRAC_W-1:0], 32'h0};
		mb = (eb == 8'h00) ? '0 : {1'b1, b[FRAC_W-1:0], 32'h0};
		if (nan_a || nan_b) begin
			r.res = '1;
			r.inv = 1'b1;
		end else if (inf_a && inf_b && (sa != sb)) begin
			r.res = '1;
			r.inv = 1'b1;
		end else if (inf_a || inf_b) begin
			sr = inf_a ? sa : sb;
			r.res = {sr, EXP_ALL1, 31'h0};
		end else begin
			// order by magnitude so the subtraction never goes negative
			if ({eb, mb} > {ea, ma}) begin
				el = eb; ml = mb; sl = sb;
				es = ea; ms = ma; ss = sa;
			end else begin
				el = ea; ml = ma; sl = sa;
				es = eb; ms = mb; ss = sb;
			end
			sh = ms >> (el - es);
			// shifted-out bits fold into a sticky lsb
			sh[0] = sh[0] | ((ms & ((64'h1 << (el - es)) - 64'h1)) != '0);
			sum = (sl == ss) ? ({1'b0, ml} + {1'b0, sh}) : ({1'b0, ml} - {1'b0, sh});
			if (sum == '0) begin
				r.res = {sl & ss, 39'h0};
				r.zero = 1'b1;
			end else begin
				lz = '0;
				if (sum[WORK_W]) begin
					norm = sum[WORK_W:1] | {63'h0, sum[0]};
					e = $signed({3'b0, el}) + 11'sd1;
				end else begin
					lz = lead_zeros(sum[WORK_W-1:0]);
					norm = sum[WORK_W-1:0] << lz;
					e = $signed({3'b0, el}) - $signed({5'b0, lz});
				end
				if (rnd32) begin
					kept = {1'b0, norm[63:40], 8'h00};
					g = norm[39];
					st = norm[38:0] != '0;
					lsb = norm[40];
					unit = 33'h100;
				end else begin
					kept = {1'b0, norm[63:32]};
					g = norm[31];
					st = norm[30:0] != '0;
					lsb = norm[32];
					unit = 33'h1;
				end
				if (!trunc && g && (st || lsb)) begin
					kept = kept + unit;
				end
				if (kept[32]) begin
					kept = {1'b0, 32'h80000000};
					e = e + 11'sd1;
				end
				if (e >= EXP_OVF_LIM) begin
					r.ovf = 1'b1;
					if (trunc) begin
						r.res = {sl, EXP_MAXNORM, rnd32 ? {23'h7fffff, 8'h00} : 31'h7fffffff};
					end else begin
						r.res = {sl, EXP_ALL1, 31'h0};
					end
				end else if (e <= 11'sd0) begin
					r.res = {sl, 39'h0};
					r.zero = 1'b1;
				end else begin
					r.res = {sl, e[7:0], kept[30:0]};
				end
			end
		end
		// magnitude only, nan stays all ones
		if (absr && !(nan_a || nan_b) && !r.inv) begin
			r.res[OPND_W-1] = 1'b0;
		end
		r.neg = r.res[OPND_W-1] && !(nan_a || nan_b) && !r.inv && !absr;
		return r;
	endfunction

	// ****************************************************************
	// request decode
	// ****************************************************************
	logic req;
	logic wr_now;
	logic hi_zero;
	logic [7:0] adr;

	// writes land only on the edge where ack is sampled high
	assign req = WB_CYC_I & WB_STB_I;
	assign wr_now = req & s.ack & WB_WE_I;
	assign adr = WB_ADR_I[7:0];
	assign hi_zero = (WB_ADR_I >> 8) == '0;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		logic signed [31:0] fa, fb, fix_res;
		logic [32:0] mag_a, mag_b;
		logic [31:0] w;
		mmcf_fres_t fr;
		logic [2:0] opc;
		next_s = s;
		fa = $signed(s.src_a[OPND_W-1:EXT_W]);
		fb = $signed(s.src_b[OPND_W-1:EXT_W]);
		fix_res = '0;
		mag_a = fa[31] ? 33'(-$signed({fa[31], fa})) : {1'b0, fa};
		mag_b = fb[31] ? 33'(-$signed({fb[31], fb})) : {1'b0, fb};
		w = '0;
		opc = WB_DAT_I[2:0];
		fr = fp_addsub(s.src_a, s.src_b, opc == OP_FSUB, opc == OP_FABSADD,
			s.mode[MODE_TRUNC_BIT], s.mode[MODE_RND32_BIT]);

		// registered ack, one cycle high per request
		next_s.ack = req & !s.ack;

		// read data captured on the first cycle of a read
		if (req && !s.ack && !WB_WE_I) begin
			next_s.rdata = '0;
			if (!hi_zero) begin
				next_s.rdata = '0;
			end else if (adr == OFF_MODE) begin
				next_s.rdata = {30'h0, s.mode};
			end else if (adr == OFF_SRCA_HI) begin
				next_s.rdata = s.src_a[OPND_W-1:EXT_W];
			end else if (adr == OFF_SRCA_EXT) begin
				next_s.rdata = {24'h0, s.src_a[EXT_W-1:0]};
			end else if (adr == OFF_SRCB_HI) begin
				next_s.rdata = s.src_b[OPND_W-1:EXT_W];
			end else if (adr == OFF_SRCB_EXT) begin
				next_s.rdata = {24'h0, s.src_b[EXT_W-1:0]};
			end else if (adr == OFF_RES_HI) begin
				next_s.rdata = s.res[OPND_W-1:EXT_W];
			end else if (adr == OFF_RES_EXT) begin
				next_s.rdata = {24'h0, s.res[EXT_W-1:0]};
			end else if (adr == OFF_STATUS) begin
				w[STAT_ZERO_BIT] = s.flags.zero;
				w[STAT_OVF_BIT] = s.flags.ovf;
				w[STAT_NEG_BIT] = s.flags.neg;
				w[STAT_CARRY_BIT] = s.flags.carry;
				w[STAT_SIGN_BIT] = s.flags.sign;
				w[STAT_INV_BIT] = s.flags.inv;
				w[STAT_FOP_BIT] = s.flags.fop;
				w[STAT_CMP_LSB +: 8] = s.cmp_hist;
				next_s.rdata = w;
			end else if (adr == OFF_STICKY) begin
				next_s.rdata = {28'h0, s.sticky};
			end
		end

		// register writes; unmapped addresses are acked and dropped
		if (wr_now && hi_zero) begin
			if (adr == OFF_MODE) begin
				next_s.mode = 2'(merge_lanes({30'h0, s.mode}, WB_DAT_I, WB_SEL_I));
			end else if (adr == OFF_SRCA_HI) begin
				next_s.src_a[OPND_W-1:EXT_W] = merge_lanes(s.src_a[OPND_W-1:EXT_W],
					WB_DAT_I, WB_SEL_I);
			end else if (adr == OFF_SRCA_EXT && WB_SEL_I[0]) begin
				next_s.src_a[EXT_W-1:0] = WB_DAT_I[7:0];
			end else if (adr == OFF_SRCB_HI) begin
				next_s.src_b[OPND_W-1:EXT_W] = merge_lanes(s.src_b[OPND_W-1:EXT_W],
					WB_DAT_I, WB_SEL_I);
			end else if (adr == OFF_SRCB_EXT && WB_SEL_I[0]) begin
				next_s.src_b[EXT_W-1:0] = WB_DAT_I[7:0];
			end else if (adr == OFF_STICKY && WB_SEL_I[0]) begin
				// write one to clear
				next_s.sticky = s.sticky & ~WB_DAT_I[3:0];
			end
		end

		// command write launches one operation; unknown codes do nothing
		if (wr_now && hi_zero && adr == OFF_CMD && WB_SEL_I[0]) begin
			case (opc)
				OP_MIN, OP_MAX, OP_CLIP: begin
					if (opc == OP_MIN) begin
						fix_res = (fa < fb) ? fa : fb;
					end else if (opc == OP_MAX) begin
						fix_res = (fa > fb) ? fa : fb;
					end else if (mag_a < mag_b) begin
						fix_res = fa;
					end else if (!fa[31]) begin
						fix_res = mag_b[31:0];
					end else begin
						fix_res = 32'(-$signed(mag_b));
					end
					next_s.res = {fix_res, 8'h00};
					next_s.flags = '0;
					next_s.flags.neg = fix_res[31];
					next_s.flags.zero = (fix_res == '0);
					next_s.sticky = next_s.sticky;
				end
				OP_FADD, OP_FSUB, OP_FABSADD: begin
					next_s.res = fr.res;
					next_s.flags = '0;
					next_s.flags.fop = 1'b1;
					next_s.flags.inv = fr.inv;
					next_s.flags.ovf = fr.ovf;
					next_s.flags.zero = fr.zero;
					next_s.flags.neg = fr.neg;
					if (fr.zero) begin
						next_s.sticky[STK_UNDER_BIT] = 1'b1;
					end
					if (fr.inv) begin
						next_s.sticky[STK_INV_BIT] = 1'b1;
					end
					if (fr.ovf) begin
						next_s.sticky[STK_FOVF_BIT] = 1'b1;
					end
				end
				default: begin
					next_s.res = s.res;
				end
			endcase
			next_s.cmp_hist = s.cmp_hist;
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			s <= '0;
			s.mode <= MODE_RST;
			s.sticky <= STICKY_RST;
			s.cmp_hist <= CMP_RST;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from flops
	assign WB_DAT_O = s.rdata;
	assign WB_ACK_O = s.ack;

endmodule

`default_nettype wire

// >>> inc/mmcf_pkg.sv
// constants, types and register map of the min/max/clip and float add/sub unit
package mmcf_pkg;

	// ****************************************************************
	// widths and operand layout
	// ****************************************************************
	localparam int DATA_W = 32;
	localparam int OPND_W = 40;
	localparam int EXT_W = 8;
	localparam int FRAC_W = 31;
	localparam int WORK_W = 64;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_SRCA_HI = 8'h04;
	localparam logic [7:0] OFF_SRCA_EXT = 8'h08;
	localparam logic [7:0] OFF_SRCB_HI = 8'h0c;
	localparam logic [7:0] OFF_SRCB_EXT = 8'h10;
	localparam logic [7:0] OFF_CMD = 8'h14;
	localparam logic [7:0] OFF_RES_HI = 8'h18;
	localparam logic [7:0] OFF_RES_EXT = 8'h1c;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	localparam logic [7:0] OFF_STICKY = 8'h24;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int MODE_TRUNC_BIT = 0;
	localparam int MODE_RND32_BIT = 1;
	localparam int STAT_ZERO_BIT = 0;
	localparam int STAT_OVF_BIT = 1;
	localparam int STAT_NEG_BIT = 2;
	localparam int STAT_CARRY_BIT = 3;
	localparam int STAT_SIGN_BIT = 4;
	localparam int STAT_INV_BIT = 5;
	localparam int STAT_FOP_BIT = 6;
	localparam int STAT_CMP_LSB = 24;
	localparam int STK_UNDER_BIT = 0;
	localparam int STK_FIXOVF_BIT = 1;
	localparam int STK_INV_BIT = 2;
	localparam int STK_FOVF_BIT = 3;

	// ****************************************************************
	// values after reset and float encodings
	// ****************************************************************
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [3:0] STICKY_RST = 4'h0;
	localparam logic [7:0] CMP_RST = 8'h00;
	localparam logic [7:0] EXP_ALL1 = 8'hff;
	localparam logic [7:0] EXP_MAXNORM = 8'hfe;
	localparam logic signed [10:0] EXP_OVF_LIM = 11'sh0ff;

	// operation codes written to the command register
	typedef enum logic [2:0] {OP_MIN, OP_MAX, OP_CLIP, OP_FADD, OP_FSUB, OP_FABSADD} mmcf_op_t;

	// live arithmetic flags
	typedef struct packed {
		logic zero;
		logic ovf;
		logic neg;
		logic carry;
		logic sign;
		logic inv;
		logic fop;
	} mmcf_flags_t;

	// float result bundle
	typedef struct packed {
		logic [OPND_W-1:0] res;
		logic inv;
		logic ovf;
		logic zero;
		logic neg;
	} mmcf_fres_t;

endpackage

// >>> verification/mmcf_unit_assertions.sv
// bus timing and flag checks for the min/max/clip and float unit
`timescale 1ns/1ps
`default_nettype none
module mmcf_unit_assertions
	import mmcf_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	// wishbone
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [ADDR_W-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [DATA_W-1:0] WB_DAT_I,
	input wire logic [DATA_W-1:0] WB_DAT_O,
	input wire logic WB_ACK_O
);
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!RESETN_I);

	// ****************************************************************
	// helper state
	// ****************************************************************
	logic [2:0] last_op;
	logic [31:0] res_seen;
	logic res_ok;
	logic rd_ack;
	logic st_rd;
	logic fix_op;
	logic fl;
	assign rd_ack = WB_ACK_O && !WB_WE_I;
	assign st_rd = rd_ack && WB_ADR_I == ADDR_W'(OFF_STATUS);
	assign fix_op = last_op < 3'h3;
	assign fl = last_op inside {3'h3, 3'h4, 3'h5};

	// last command run and result read since; 7 means none yet
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			last_op <= 3'h7;
			res_ok <= 1'b0;
			res_seen <= 32'h0;
		end else if (WB_ACK_O && WB_WE_I && WB_ADR_I == ADDR_W'(OFF_CMD)) begin
			// opcodes 6 and 7 are ignored by the unit
			last_op <= (WB_SEL_I[0] && WB_DAT_I[2:0] < 3'h6) ? WB_DAT_I[2:0] : last_op;
			res_ok <= 1'b0;
		end else if (rd_ack && WB_ADR_I == ADDR_W'(OFF_RES_HI)) begin
			res_seen <= WB_DAT_O;
			res_ok <= 1'b1;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	ack_after_req_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("ack missing one cycle after request");
	ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held longer than one cycle");
	cmp_hist_zero_a: assert property (st_rd |-> WB_DAT_O[31:24] == CMP_RST)
		else $error("compare history bits changed");
	fixed_ext_zero_a: assert property (
		rd_ack && fix_op && WB_ADR_I == ADDR_W'(OFF_RES_EXT) |-> WB_DAT_O[7:0] == 8'h00)
		else $error("fixed result extension not zero");
	float_op_flag_a: assert property (st_rd && fl |-> WB_DAT_O[STAT_FOP_BIT])
		else $error("float op flag not set");
	fixed_flags_clr_a: assert property (st_rd && fix_op |-> (WB_DAT_O & 32'h3a) == 32'h0)
		else $error("fixed op left carry, sign, overflow or invalid set");
	float_flags_clr_a: assert property (st_rd && fl |-> (WB_DAT_O & 32'h18) == 32'h0)
		else $error("float op left carry or sign set");
	abs_neg_clr_a: assert property (
		st_rd && last_op == 3'h5 |-> !WB_DAT_O[STAT_NEG_BIT])
		else $error("abs sum left negative flag set");
	fixed_zero_flag_a: assert property (
		st_rd && fix_op && res_ok |-> WB_DAT_O[STAT_ZERO_BIT] == (res_seen == 32'h0))
		else $error("zero flag disagrees with fixed result");
	fixed_neg_flag_a: assert property (
		st_rd && fix_op && res_ok |-> WB_DAT_O[STAT_NEG_BIT] == res_seen[31])
		else $error("negative flag disagrees with fixed result msb");
endmodule
`default_nettype wire

// >>> verification/mmcf_seq.sv
// wishbone master standing in for the core sequencer
`timescale 1ns/1ps
`default_nettype none
module mmcf_seq
	import mmcf_pkg::*;
(
	// clock and answer
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [DATA_W-1:0] dat_i,
	// request
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [DATA_W-1:0] dat_o
);
	bit hang;

	// idle bus at time zero
	initial begin
		hang = 1'b0;
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end

	// one classic cycle; held until ack is sampled, bounded so a dead slave ends it
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= we;
		adr_o <= adr;
		sel_o <= 4'hf;
		dat_o <= wd;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && n < 50);
		hang = (ack_i !== 1'b1);
		rd = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the min/max/clip and float unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import mmcf_pkg::*;
	logic clk;
	logic rst_n;
	logic cyc, stb, we, ack;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	int fails = 0;
	int n_checks = 0;

	mmcf_unit u_mmcf_unit (.CORE_CLK_I(clk), .RESETN_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack));
	mmcf_seq u_mmcf_seq (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// a hung cycle counts as a mismatch and ends the run
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		u_mmcf_seq.xfer(w, a, d, q);
		if (u_mmcf_seq.hang) begin
			fails++;
			report_and_stop();
		end
	endtask

	task automatic run(input logic [1:0] md, input logic [2:0] op, input logic [39:0] a, b);
		bus(1'b1, OFF_MODE, {30'h0, md});
		bus(1'b1, OFF_SRCA_HI, a[39:8]);
		bus(1'b1, OFF_SRCA_EXT, {24'h0, a[7:0]});
		bus(1'b1, OFF_SRCB_HI, b[39:8]);
		bus(1'b1, OFF_SRCB_EXT, {24'h0, b[7:0]});
		bus(1'b1, OFF_CMD, {29'h0, op});
	endtask

	// run one op, compare result, status and sticky, then clear sticky
	task automatic t(input int md, input logic [2:0] op, input logic [39:0] a, b, r,
		input int st, input int sk);
		logic [39:0] v;
		run(md[1:0], op, a, b);
		bus(1'b0, OFF_RES_HI, 32'h0);
		v[39:8] = q;
		bus(1'b0, OFF_RES_EXT, 32'h0);
		v[7:0] = q[7:0];
		chk("result", v, r);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk("status", {8'h0, q}, {32'h0, st[7:0]});
		bus(1'b0, OFF_STICKY, 32'h0);
		chk("sticky", {8'h0, q}, {36'h0, sk[3:0]});
		bus(1'b1, OFF_STICKY, 32'hf);
		$display("test op %0d done", op);
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		rst_n = 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		// every register and one unmapped place read zero after reset
		for (int i = 0; i < 11; i++) begin
			bus(1'b0, 8'(i * 4), 32'h0);
			chk("reset value", {8'h0, q}, 40'h0);
		end
		$display("test reset done");
		t(0, OP_MIN, 40'h0000000511, 40'hfffffffd00, 40'hfffffffd00, 'h04, 0);
		t(0, OP_MAX, 40'h0000000500, 40'hfffffffd00, 40'h0000000500, 'h00, 0);
		t(0, OP_MAX, 40'h0000000000, 40'h8000000000, 40'h0000000000, 'h01, 0);
		t(0, OP_CLIP, 40'h0000000a00, 40'hfffffffc00, 40'h0000000400, 'h00, 0);
		t(0, OP_CLIP, 40'hfffffff600, 40'h0000000400, 40'hfffffffc00, 'h04, 0);
		t(0, OP_CLIP, 40'hfffffffd00, 40'h0000000400, 40'hfffffffd00, 'h04, 0);
		t(0, OP_FADD, 40'h3f80000000, 40'h4000000000, 40'h4040000000, 'h40, 0);
		t(0, OP_FSUB, 40'h3f80000000, 40'h4000000000, 40'hbf80000000, 'h44, 0);
		t(0, OP_FADD, 40'h3f80000000, 40'hbf80000000, 40'h0000000000, 'h41, 1);
		t(0, OP_FADD, 40'h0040000000, 40'h0040000000, 40'h0000000000, 'h41, 1);
		t(0, OP_FSUB, 40'h0080000100, 40'h0080000000, 40'h0000000000, 'h41, 1);
		t(0, OP_FADD, 40'h7fc0000000, 40'h3f80000000, 40'hffffffffff, 'h60, 4);
		t(0, OP_FADD, 40'h7f80000000, 40'hff80000000, 40'hffffffffff, 'h60, 4);
		t(0, OP_FADD, 40'h7f80000000, 40'h7f80000000, 40'h7f80000000, 'h40, 0);
		t(0, OP_FSUB, 40'h7f80000000, 40'h7f80000000, 40'hffffffffff, 'h60, 4);
		t(0, OP_FSUB, 40'h7f80000000, 40'hff80000000, 40'h7f80000000, 'h40, 0);
		t(0, OP_FADD, 40'h7f7fffff00, 40'h7f7fffff00, 40'h7f80000000, 'h42, 8);
		t(1, OP_FSUB, 40'h7f7fffff00, 40'hff7fffff00, 40'h7f7fffffff, 'h42, 8);
		t(0, OP_FABSADD, 40'hff7fffff00, 40'hff7fffff00, 40'h7f80000000, 'h42, 8);
		t(0, OP_FABSADD, 40'hbf80000000, 40'hc000000000, 40'h4040000000, 'h40, 0);
		t(0, OP_FADD, 40'h3f80000003, 40'h3f80000000, 40'h4000000002, 'h40, 0);
		t(1, OP_FADD, 40'h3f80000003, 40'h3f80000000, 40'h4000000001, 'h40, 0);
		t(2, OP_FADD, 40'h3f80000003, 40'h3f80000000, 40'h4000000000, 'h40, 0);
		t(2, OP_FADD, 40'h3f80000180, 40'h3f80000000, 40'h4000000100, 'h40, 0);
		t(3, OP_FADD, 40'h3f80000180, 40'h3f80000000, 40'h4000000000, 'h40, 0);
		// a fixed op after an invalid float op keeps the invalid sticky
		run(2'h0, OP_FADD, 40'h7fc0000000, 40'h3f80000000);
		t(0, OP_MIN, 40'h0000000100, 40'h0000000200, 40'h0000000100, 'h00, 4);
		// an unused opcode leaves the result alone
		bus(1'b1, OFF_CMD, 32'h7);
		bus(1'b0, OFF_RES_HI, 32'h0);
		chk("ignored opcode", {8'h0, q}, 40'h0000000001);
		report_and_stop();
	end
endmodule

bind mmcf_unit mmcf_unit_assertions #(.ADDR_W(ADDR_W)) u_mmcf_unit_assertions (
	.CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O));
`default_nettype wire
